// >>> src/serial_ctrl_defines.vh
`ifndef SERIAL_CTRL_DEFINES_VH
`define SERIAL_CTRL_DEFINES_VH
`define ADDR_CONTROL_ONE    2'h0
`define ADDR_CONTROL_TWO    2'h1
`define ADDR_STATUS         2'h2
`define ADDR_DATA           2'h3
`define C1_RX_IRQ_EN        7
`define C1_ENABLE           6
`define C1_TX_IRQ_EN        5
`define C1_MASTER           4
`define C1_POLARITY         3
`define C1_PHASE            2
`define C1_SEL_OE           1
`define C1_LOW_FIRST        0
`define C2_FAULT_EN         4
`define C2_BIDIR_OE         3
`define C2_WAIT_STOP        1
`define C2_SINGLE_WIRE      0
`define C2_IMPL_MASK        8'h1B
`define C1_RESET            8'h00
`define C2_RESET            8'h00
`define ST_RX_FULL          7
`define ST_FAULT            4
`define ST_TX_EMPTY         5
`define HALF_BIT_CYCLES     8'h04
`endif

// >>> src/serial_shifter.v
`timescale 1ns/1ns
module serial_shifter #(
  parameter HALF = 8'h04
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire       master,
  input  wire       phase,
  input  wire       low_first,
  input  wire       start,
  input  wire [7:0] tx_byte,
  input  wire       sck_lvl,
  input  wire       sel_n,
  input  wire       din,
  output reg        sck_q,
  output reg        dout_q,
  output reg        busy_q,
  output reg        done_q,
  output reg  [7:0] rx_q
);
  reg [7:0] sh_q;
  reg [7:0] div_q;
  reg [4:0] edge_q;
  reg       sck_prev_q;
  wire      tick = (div_q == HALF - 8'h01);
  wire      out_bit = low_first ? sh_q[0] : sh_q[7];
  wire      s_edge = busy_q & ~master & (sck_lvl ^ sck_prev_q);
  wire      any_edge = master ? (busy_q & tick) : s_edge;
  // Odd edges sample for phase 0, even edges for phase 1
  wire      samp = (edge_q[0] == phase);
  wire [7:0] sh_in = low_first ? {din, sh_q[7:1]} : {sh_q[6:0], din};
  always @(posedge clk) begin
    done_q <= 1'b0;
    if (rst || !run) begin
      sh_q <= 8'h00;
      div_q <= 8'h00;
      edge_q <= 5'h00;
      sck_q <= 1'b0;
      busy_q <= 1'b0;
      dout_q <= 1'b0;
      rx_q <= 8'h00;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_lvl;
      div_q <= (tick || !busy_q) ? 8'h00 : div_q + 8'h01;
      if (!busy_q && (start || (!master && !sel_n))) begin
        busy_q <= 1'b1;
        sh_q <= tx_byte;
        edge_q <= 5'h00;
        sck_q <= 1'b0;
        dout_q <= low_first ? tx_byte[0] : tx_byte[7];
      end else if (busy_q && !master && sel_n) begin
        busy_q <= 1'b0;
      end else if (any_edge) begin
        edge_q <= edge_q + 5'h01;
        if (master)
          sck_q <= ~sck_q;
        if (samp)
          sh_q <= sh_in;
        if (!samp) begin
          dout_q <= out_bit;
        end
        if (edge_q == 5'h0F) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
          rx_q <= samp ? sh_in : sh_q;
          sck_q <= 1'b0;
        end
      end
    end
  end
endmodule // serial_shifter

// >>> src/serial_control.v
// Functional notes
// - Receive-full or fault raises irq when enabled
// - Disable halts, clears buffers, flags reset
// - Transmit-empty raises irq when enabled
// - Master select picks master or slave
// - Polarity inverts clock and idle level
// - Phase picks first edge mid or start
// - Low-bit-first picks shift order
// - Master without fault enable frees select
// - Master fault enable, no oe: fault input
// - Slave: select is input, options ignored
// - Unused second control bits read zero
// - Bidir oe drives single data pin
// - Separate pins ignore bidir oe
// - Wait stop bit halts clocks in wait
// - Slave single wire uses slave-out pin
// - Master single wire uses master-out pin
// - Pin control picks separate or single
// - Disabled: all four pins released
`timescale 1ns/1ns
`include "serial_ctrl_defines.vh"
module serial_control (
  input  wire       clk,
  input  wire       rst,
  input  wire [1:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata_q,
  input  wire       wait_mode,
  input  wire       sck_in,
  input  wire       mosi_in,
  input  wire       miso_in,
  input  wire       sel_in,
  output reg        sck_out_q,
  output reg        sck_oe_q,
  output reg        mosi_out_q,
  output reg        mosi_oe_q,
  output reg        miso_out_q,
  output reg        miso_oe_q,
  output reg        sel_out_q,
  output reg        sel_oe_q,
  output reg        irq_q
);
  reg  [7:0] c1_q;
  reg  [7:0] c2_q;
  reg  [7:0] txbuf_q;
  reg        tx_empty_q;
  reg        rx_full_q;
  reg        fault_q;
  reg  [7:0] rxbuf_q;
  reg        st_seen_tx_q;
  reg        st_seen_rx_q;
  reg  [3:0] meta_q;
  reg  [3:0] sync_q;
  reg        load_q;
  wire       en = c1_q[`C1_ENABLE];
  wire       mst = c1_q[`C1_MASTER];
  wire       pol = c1_q[`C1_POLARITY];
  wire       single = c2_q[`C2_SINGLE_WIRE];
  wire       boe = c2_q[`C2_BIDIR_OE];
  wire       fen = c2_q[`C2_FAULT_EN];
  wire       soe = c1_q[`C1_SEL_OE];
  wire       stopped = c2_q[`C2_WAIT_STOP] & wait_mode;
  wire       run = en & ~stopped;
  wire       sck_s = sync_q[0];
  wire       mosi_s = sync_q[1];
  wire       miso_s = sync_q[2];
  wire       sel_s = sync_q[3];
  wire       fault_in = en & mst & fen & ~soe & ~sel_s;
  wire       din;
  wire       sck_core;
  wire       dout;
  wire       busy;
  wire       done;
  wire [7:0] rx_byte;
  wire       rd_st = rd && (addr == `ADDR_STATUS);
  wire       rd_dat = rd && (addr == `ADDR_DATA);
  wire       wr_dat = wr && (addr == `ADDR_DATA);
  // Slave single wire reads the slave-out pin, master reads master-out
  assign din = single ? (mst ? mosi_s : miso_s) : (mst ? miso_s : mosi_s);
  // Both synchroniser stages before any logic reads the pins
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= 4'h0;
      sync_q <= 4'hF;
    end else begin
      meta_q <= {sel_in, miso_in, mosi_in, sck_in};
      sync_q <= meta_q;
    end
  end
  // Polarity undone on input so the shifter sees idle-low clock
  serial_shifter #(.HALF(`HALF_BIT_CYCLES)) u_shift (
    .clk       (clk),
    .rst       (rst),
    .run       (run & ~fault_q),
    .master    (mst),
    .phase     (c1_q[`C1_PHASE]),
    .low_first (c1_q[`C1_LOW_FIRST]),
    .start     (load_q),
    .tx_byte   (txbuf_q),
    .sck_lvl   (sck_s ^ pol),
    .sel_n     (sel_s),
    .din       (din),
    .sck_q     (sck_core),
    .dout_q    (dout),
    .busy_q    (busy),
    .done_q    (done),
    .rx_q      (rx_byte)
  );
  always @(posedge clk) begin
    if (rst) begin
      c1_q <= `C1_RESET;
      c2_q <= `C2_RESET;
    end else if (wr) begin
      if (addr == `ADDR_CONTROL_ONE)
        c1_q <= wdata;
      if (addr == `ADDR_CONTROL_TWO)
        c2_q <= wdata & `C2_IMPL_MASK;
    end
  end
  // Transmit buffer, flags; set wins over software clear
  always @(posedge clk) begin
    load_q <= 1'b0;
    if (rst || !en) begin
      txbuf_q <= 8'h00;
      tx_empty_q <= 1'b1;
      rx_full_q <= 1'b0;
      rxbuf_q <= 8'h00;
      fault_q <= 1'b0;
      st_seen_tx_q <= 1'b0;
      st_seen_rx_q <= 1'b0;
    end else begin
      if (rd_st) begin
        st_seen_tx_q <= tx_empty_q;
        st_seen_rx_q <= rx_full_q;
      end
      if (wr_dat && st_seen_tx_q && tx_empty_q) begin
        txbuf_q <= wdata;
        tx_empty_q <= 1'b0;
        st_seen_tx_q <= 1'b0;
      end
      if (!tx_empty_q && !busy && !load_q && mst) begin
        load_q <= 1'b1;
        tx_empty_q <= 1'b1;
      end
      if (!mst && !busy && !tx_empty_q && sel_s)
        load_q <= 1'b1;
      if (!mst && load_q)
        tx_empty_q <= 1'b1;
      if (rd_dat && st_seen_rx_q) begin
        rx_full_q <= 1'b0;
        st_seen_rx_q <= 1'b0;
      end
      if (done) begin
        rxbuf_q <= rx_byte;
        rx_full_q <= 1'b1;
      end
      if (fault_in) begin
        fault_q <= 1'b1;
      end else if (rd_st && fault_q && wr == 1'b0) begin
        fault_q <= fault_q;
      end
      if (wr && addr == `ADDR_CONTROL_ONE && fault_q && !fault_in)
        fault_q <= 1'b0;
    end
  end
  // Pin muxing; drivers only while enabled
  always @(posedge clk) begin
    if (rst || !en) begin
      sck_out_q <= 1'b0;
      sck_oe_q <= 1'b0;
      mosi_out_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_out_q <= 1'b0;
      miso_oe_q <= 1'b0;
      sel_out_q <= 1'b1;
      sel_oe_q <= 1'b0;
    end else begin
      sck_out_q <= sck_core ^ pol;
      sck_oe_q <= mst & ~fault_q;
      mosi_out_q <= dout;
      miso_out_q <= dout;
      if (single) begin
        mosi_oe_q <= mst & boe;
        miso_oe_q <= ~mst & boe & ~sel_s;
      end else begin
        mosi_oe_q <= mst & ~fault_q;
        miso_oe_q <= ~mst & ~sel_s;
      end
      sel_out_q <= ~(busy | load_q);
      sel_oe_q <= mst & fen & soe;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      irq_q <= (c1_q[`C1_RX_IRQ_EN] & (rx_full_q | fault_q))
             | (c1_q[`C1_TX_IRQ_EN] & tx_empty_q);
      rdata_q <= 8'h00;
      if (rd) begin
        case (addr)
          `ADDR_CONTROL_ONE: rdata_q <= c1_q;
          `ADDR_CONTROL_TWO: rdata_q <= c2_q & `C2_IMPL_MASK;
          `ADDR_STATUS: rdata_q <= {rx_full_q, 1'b0, tx_empty_q,
                                    fault_q, 4'h0};
          default: rdata_q <= rxbuf_q;
        endcase
      end
    end
  end
endmodule // serial_control

// >>> tb/serial_control_asserts.sv
`timescale 1ns/1ns
module serial_control_asserts (
  input wire       clk,
  input wire       rst,
  input wire [1:0] addr,
  input wire [7:0] wdata,
  input wire       wr,
  input wire       rd,
  input wire [7:0] rdata_q,
  input wire       sck_out_q,
  input wire       sck_oe_q,
  input wire       mosi_oe_q,
  input wire       sel_oe_q,
  input wire       irq_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire w1 = wr && addr == 2'h0;
  property p_rst;
    $fell(rst) |-> !irq_q && !sck_oe_q && !sel_oe_q;
  endproperty
  a_rst: assert property (p_rst) else $error("Active after reset");
  property p_c2z;
    rd && addr == 2'h1 |=> rdata_q[7:5] == 3'h0 && !rdata_q[2];
  endproperty
  a_c2z: assert property (p_c2z) else $error("Unused bit set");
  property p_off;
    w1 && !wdata[6] |-> ##[1:3] !(sck_oe_q | mosi_oe_q | sel_oe_q);
  endproperty
  a_off: assert property (p_off) else $error("Pin held");
  property p_txi;
    w1 && wdata[6:5] == 2'h1 |-> ##[1:3] irq_q;
  endproperty
  a_txi: assert property (p_txi) else $error("No tx irq");
  property p_noi;
    w1 && wdata[7:5] == 3'h0 |-> ##3 !irq_q;
  endproperty
  a_noi: assert property (p_noi) else $error("Irq not masked");
  property p_pol;
    w1 && wdata[6:4] == 3'h5 |-> ##3 sck_oe_q && sck_out_q == $past(wdata[3], 3);
  endproperty
  a_pol: assert property (p_pol) else $error("Idle level");
  property p_slv;
    w1 && wdata[6:4] == 3'h4 |-> ##3 !sck_oe_q && !sel_oe_q;
  endproperty
  a_slv: assert property (p_slv) else $error("Slave drives");
  property p_rb;
    w1 ##2 rd && addr == 2'h0 |=> rdata_q == $past(wdata, 2);
  endproperty
  a_rb: assert property (p_rb) else $error("Readback");
endmodule // serial_control_asserts
bind serial_control serial_control_asserts serial_control_asserts_i (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata_q(rdata_q), .sck_out_q(sck_out_q), .sck_oe_q(sck_oe_q),
  .mosi_oe_q(mosi_oe_q), .sel_oe_q(sel_oe_q), .irq_q(irq_q));

// >>> tb/serial_partner.sv
`timescale 1ns/1ns
module serial_partner (
  input  wire       sck,
  input  wire       mosi,
  input  wire       sel_n,
  input  wire       clock_polarity,
  input  wire       clock_phase,
  input  wire       lsb,
  input  wire [7:0] tx,
  output wire       miso,
  output reg  [7:0] rx
);
  reg [7:0] sh = 8'h00;
  reg       got = 1'b0;
  reg       last = 1'b0;
  wire      b = lsb ? sh[0] : sh[7];
  // Released line flips, so a stale bit never passes
  assign miso = sel_n ? ~last : b;
  always @(negedge sel_n) begin
    sh = tx;
    got = 1'b0;
  end
  always @(sck) begin
    if (!sel_n) begin
      if ((sck != clock_polarity) != clock_phase) begin
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        got = 1'b1;
      end else if (got) begin
        last = b;
        sh = lsb ? sh >> 1 : sh << 1;
      end
    end
  end
endmodule // serial_partner

// >>> tb/tb.sv
`timescale 1ns/1ns
module tb;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg  [1:0] addr = 2'h0;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg        psel_n = 1'b1;
  reg  [7:0] ptx = 8'h00;
  reg  [7:0] c1 = 8'h00;
  reg  [7:0] d;
  integer    fail_count = 0;
  integer    comparisons = 0;
  integer    i;
  integer    k;
  wire [7:0] rdata_q;
  wire [7:0] prx;
  wire sck_out_q, sck_oe_q, mosi_out_q, mosi_oe_q, miso_out_q, miso_oe_q;
  wire sel_out_q, sel_oe_q, irq_q, pmiso;
  wire sck_w = sck_oe_q ? sck_out_q : 1'b0;
  wire mosi_w = mosi_oe_q ? mosi_out_q : 1'b1;
  always #10 clk = ~clk;
  serial_control serial_control_i (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata_q(rdata_q), .wait_mode(1'b0), .sck_in(sck_w), .mosi_in(mosi_w),
    .miso_in(miso_oe_q ? miso_out_q : pmiso),
    .sel_in(sel_oe_q ? sel_out_q : psel_n), .sck_out_q(sck_out_q),
    .sck_oe_q(sck_oe_q), .mosi_out_q(mosi_out_q), .mosi_oe_q(mosi_oe_q),
    .miso_out_q(miso_out_q), .miso_oe_q(miso_oe_q), .sel_out_q(sel_out_q),
    .sel_oe_q(sel_oe_q), .irq_q(irq_q));
  serial_partner serial_partner_i (
    .sck(sck_w), .mosi(mosi_w), .sel_n(psel_n), .clock_polarity(c1[3]),
    .clock_phase(c1[2]), .lsb(c1[0]), .tx(ptx), .miso(pmiso), .rx(prx));
  task test_done;
    begin
      $display("Mismatches %0d of %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [7:0] g, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // A gap cycle after each strobe keeps one assignment per time step
  task wreg(input [1:0] a, input [7:0] v);
    begin
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rget(input [1:0] a);
    begin
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata_q;
      @(posedge clk);
    end
  endtask
  task pins(input [7:0] a, input [7:0] b, input [2:0] e);
    begin
      wreg(2'h1, b);
      wreg(2'h0, a);
      repeat (3) @(posedge clk);
      #1;
      chk({5'h0, sel_oe_q, mosi_oe_q, sck_oe_q}, {5'h0, e});
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rget(2'h0);
    chk(d, 8'h00);
    rget(2'h1);
    chk(d, 8'h00);
    chk({sck_oe_q, mosi_oe_q, sel_oe_q, irq_q}, 8'h00);
    // Phase changes only while enabled, never with a disable
    for (i = 0; i < 8; i = i + 1) begin
      c1 = {4'hD, i[2], i[1], 1'b0, i[0]};
      wreg(2'h0, c1);
      rget(2'h0);
      chk(d, c1);
      chk({7'h0, sck_out_q}, {7'h0, c1[3]});
      ptx = 8'hC1 + i[7:0];
      psel_n = 1'b0;
      rget(2'h2);
      wreg(2'h3, 8'h35 + i[7:0]);
      d = 8'h00;
      for (k = 0; k < 200 && !d[7]; k = k + 1)
        rget(2'h2);
      if (!d[7]) begin
        fail_count = fail_count + 1;
        test_done;
      end
      chk({7'h0, irq_q}, 8'h01);
      psel_n = 1'b1;
      rget(2'h3);
      chk(d, ptx);
      chk(prx, 8'h35 + i[7:0]);
    end
    pins(8'h50, 8'h00, 3'h3);
    pins(8'h52, 8'h00, 3'h3);
    pins(8'h52, 8'h10, 3'h7);
    pins(8'h50, 8'h10, 3'h3);
    // Low select on a master with fault input enabled raises a fault
    wreg(2'h0, 8'hD0);
    psel_n <= 1'b0;
    repeat (5) @(posedge clk);
    rget(2'h2);
    chk(d, 8'h30);
    chk({7'h0, sck_oe_q}, 8'h00);
    chk({7'h0, irq_q}, 8'h01);
    psel_n <= 1'b1;
    repeat (3) @(posedge clk);
    pins(8'h42, 8'h10, 3'h0);
    pins(8'h50, 8'h09, 3'h3);
    pins(8'h50, 8'h01, 3'h1);
    pins(8'h50, 8'h08, 3'h3);
    pins(8'h12, 8'h10, 3'h0);
    wreg(2'h1, 8'hFF);
    rget(2'h1);
    chk(d, 8'h1B);
    wreg(2'h0, 8'h20);
    rget(2'h0);
    chk({7'h0, irq_q}, 8'h01);
    wreg(2'h0, 8'h00);
    rget(2'h0);
    chk({7'h0, irq_q}, 8'h00);
    test_done;
  end
endmodule // tb
